// file: src/sppc_pkg.sv
package sppc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] SPPC_CMD_OFF = 8'h00;
	localparam logic [7:0] SPPC_REPLY_OFF = 8'h04;
	localparam logic [7:0] SPPC_STATUS_OFF = 8'h08;
	localparam logic [7:0] SPPC_INF_OFF = 8'h0c;
	localparam logic [7:0] SPPC_WDR_OFF = 8'h10;
	localparam logic [7:0] SPPC_BORE_OFF = 8'h14;
	localparam logic [7:0] SPPC_RATE_OFF = 8'h18;
	localparam logic [7:0] SPPC_DOSE_OFF = 8'h1c;

	// ------------------------------------------------------------
	// Command word fields
	// ------------------------------------------------------------
	localparam int SPPC_OP_MSB = 31;
	localparam int SPPC_OP_LSB = 28;
	localparam int SPPC_AUX_MSB = 27;
	localparam int SPPC_AUX_LSB = 26;
	localparam int SPPC_HASARG_BIT = 25;
	localparam int SPPC_VAL_MSB = 15;

	typedef enum logic [3:0] {
		OP_STATUS = 4'h0,
		OP_BORE_SET = 4'h1,
		OP_FLOW_SPEED = 4'h2,
		OP_DOSE_TARGET = 4'h3,
		OP_HEADING = 4'h4,
		OP_START = 4'h5,
		OP_HALT = 4'h6,
		OP_CLEAR_DELIVERED = 4'h7,
		OP_DELIVERED_QUERY = 4'h8,
		OP_ALARM_EN = 4'h9,
		OP_SAFE_MODE = 4'ha
	} sppc_op_t;

	// Reply error codes
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_OUT_OF_RANGE = 2'h1;
	localparam logic [1:0] ERR_REFUSED = 2'h2;
	localparam logic [1:0] ERR_BAD_OP = 2'h3;

	// ------------------------------------------------------------
	// Values, limits, reset values
	// ------------------------------------------------------------
	localparam logic [15:0] BORE_MIN = 16'h000a;     // 0.10 mm in hundredths
	localparam logic [15:0] BORE_MAX = 16'h1388;     // 50.00 mm
	localparam logic [15:0] BORE_UL_MAX = 16'h0578;  // 14.00 mm
	localparam logic [13:0] TOTAL_WRAP = 14'h270f;   // 9999
	localparam logic [0:0] DIR_PUSH_OUT = 1'b0;
	localparam logic [0:0] DIR_PULL_IN = 1'b1;
	localparam logic [15:0] BORE_RST = 16'h0000;
	localparam logic [15:0] RATE_RST = 16'h0000;
	localparam logic [1:0] UNITS_RST = 2'h0;
	localparam logic [15:0] DOSE_RST = 16'h0000;
	localparam logic [3:0] PHASE_FIRST = 4'h1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int BEEP_MS = 100;
	localparam int BEEP_CYC = BEEP_MS * CLK_MHZ * 1000;
	localparam int BEEP_CW = 25;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_STOP,
		ST_RUN,
		ST_PAUSE
	} sppc_state_t;

endpackage

// file: src/sppc_top.sv
// ------------------------------------------------------------
// Notes on behaviour
// - bore accepted only while program not running
// - bore 0.1..50.0 mm, else out-of-range reply
// - volumes in uL up to 14.0 mm, else mL
// - start from stopped runs phase 1, drives motor
// - nonzero dose ends phase after moved amount
// - zero dose means continuous pumping
// - running rate change immediate, not saved
// - rate units change refused while pumping
// - direction change while pumping only at zero dose
// - separate infused and withdrawn totals, queryable
// - totals cleared on power, bore, clear; wrap 9999
// - stop before completion pauses; start resumes
// - halt or setting change leaves pause
// - stall stops motor, pauses, raises alarm
// - any command clears alarm and its buzzer; power-on beep runs on
// - accepted settings saved, except running rate
// - bore change keeps other settings
// - serial commands or trigger input start/stop
// - heading selects push_out/pull_in or reports
// - short beep after power-on
// ------------------------------------------------------------
`timescale 1ns/1ps
module sppc_top
	import sppc_pkg::*;
#(
	parameter int BEEP_CYCLES = BEEP_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic trig_in,
	input wire logic vol_tick,
	input wire logic stall_det,
	input wire logic [15:0] nv_bore_in,
	input wire logic [15:0] nv_rate_in,
	input wire logic [1:0] nv_units_in,
	input wire logic [15:0] nv_dose_in,
	input wire logic nv_dir_in,
	input wire logic nv_al_in,
	input wire logic nv_safe_in,
	output logic motor_run,
	output logic motor_dir,
	output logic buzzer,
	output logic alarm_msg,
	output logic nv_save,
	output logic [15:0] nv_bore,
	output logic [15:0] nv_rate,
	output logic [1:0] nv_units,
	output logic [15:0] nv_dose,
	output logic nv_dir,
	output logic nv_al,
	output logic nv_safe
);
	import sppc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		sppc_state_t state;
		logic [3:0] phase;
		logic [15:0] bore;
		logic [15:0] rate;
		logic [15:0] rate_nv;
		logic [1:0] units;
		logic [15:0] dose;
		logic dir;
		logic al_en;
		logic safe;
		logic [13:0] inf_tot;
		logic [13:0] wdr_tot;
		logic [15:0] moved;
		logic alarm;
		logic [BEEP_CW-1:0] beep_cnt;
		logic trig_q;
		logic [1:0] reply_err;
		logic [27:0] reply_data;
		logic nv_save;
		logic alarm_msg;
		logic motor_run;
		logic buzzer;
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sppc_regs_t;

	sppc_regs_t s_r;
	sppc_regs_t s_nxt;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic bore_in_range(input logic [15:0] v);
		bore_in_range = (v >= BORE_MIN) && (v <= BORE_MAX);
	endfunction

	function automatic logic [13:0] total_step(input logic [13:0] t);
		total_step = (t >= TOTAL_WRAP) ? 14'h0000 : t + 14'h0001;
	endfunction

	function automatic logic ml_units(input logic [15:0] b);
		ml_units = b > BORE_UL_MAX;
	endfunction

	logic aw_go;
	logic w_go;
	logic ar_go;
	logic do_wr;
	logic cmd_wr;
	logic [3:0] op;
	logic [1:0] aux;
	logic has_arg;
	logic [15:0] val;
	logic trig_fall;
	logic start_req;
	logic stop_req;
	logic can_start;

	always_comb
	begin
		aw_go = awvalid && s_r.awready;
		w_go = wvalid && s_r.wready;
		ar_go = arvalid && s_r.arready;
		do_wr = (s_r.aw_hold || aw_go) && (s_r.w_hold || w_go) && !s_r.bvalid;
		cmd_wr = do_wr && ((s_r.aw_hold ? s_r.aw_addr : awaddr) == SPPC_CMD_OFF)
			&& ((s_r.w_hold ? s_r.w_strb : wstrb) == 4'hf);
		op = s_r.w_hold ? s_r.w_data[SPPC_OP_MSB:SPPC_OP_LSB] : wdata[SPPC_OP_MSB:SPPC_OP_LSB];
		aux = s_r.w_hold ? s_r.w_data[SPPC_AUX_MSB:SPPC_AUX_LSB]
			: wdata[SPPC_AUX_MSB:SPPC_AUX_LSB];
		has_arg = s_r.w_hold ? s_r.w_data[SPPC_HASARG_BIT] : wdata[SPPC_HASARG_BIT];
		val = s_r.w_hold ? s_r.w_data[SPPC_VAL_MSB:0] : wdata[SPPC_VAL_MSB:0];
		trig_fall = s_r.trig_q && !trig_in;
		can_start = bore_in_range(s_r.bore) && s_r.rate != 16'h0000;
		// Either source drives the program; trigger toggles like a foot switch
		start_req = (cmd_wr && op == OP_START) || (trig_fall && s_r.state != ST_RUN);
		stop_req = (cmd_wr && op == OP_HALT) || (trig_fall && s_r.state == ST_RUN);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic setting;
		logic saved;
		setting = 1'b0;
		saved = 1'b0;
		s_nxt = s_r;
		s_nxt.trig_q = trig_in;
		s_nxt.nv_save = 1'b0;
		s_nxt.alarm_msg = 1'b0;

		// Bus write side
		if (aw_go)
		begin
			s_nxt.aw_hold = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (w_go)
		begin
			s_nxt.w_hold = 1'b1;
			s_nxt.w_data = wdata;
			s_nxt.w_strb = wstrb;
		end
		if (do_wr)
		begin
			s_nxt.aw_hold = 1'b0;
			s_nxt.w_hold = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = ((s_r.aw_hold ? s_r.aw_addr : awaddr) == SPPC_CMD_OFF) ? 2'b00 : 2'b10;
		end
		else if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;
		s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_hold && !s_nxt.bvalid;

		// Bus read side
		if (ar_go)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = 2'b00;
			case (araddr)
				SPPC_REPLY_OFF: s_nxt.rdata = {2'b00, s_r.reply_err, s_r.reply_data};
				SPPC_STATUS_OFF: s_nxt.rdata = {16'h0000, s_r.phase, 2'b00,
					s_r.safe, s_r.al_en, s_r.buzzer, s_r.alarm, ml_units(s_r.bore),
					s_r.dir, s_r.motor_run, (s_r.state == ST_PAUSE), s_r.state};
				SPPC_INF_OFF: s_nxt.rdata = {18'h00000, s_r.inf_tot};
				SPPC_WDR_OFF: s_nxt.rdata = {18'h00000, s_r.wdr_tot};
				SPPC_BORE_OFF: s_nxt.rdata = {16'h0000, s_r.bore};
				SPPC_RATE_OFF: s_nxt.rdata = {14'h0000, s_r.units, s_r.rate};
				SPPC_DOSE_OFF: s_nxt.rdata = {16'h0000, s_r.dose};
				SPPC_CMD_OFF: s_nxt.rdata = 32'h00000000;
				default:
				begin
					s_nxt.rdata = 32'h00000000;
					s_nxt.rresp = 2'b10;
				end
			endcase
		end
		else if (s_r.rvalid && rready)
			s_nxt.rvalid = 1'b0;
		s_nxt.arready = !s_nxt.rvalid;

		// Power-on beep
		if (s_r.beep_cnt != '0)
			s_nxt.beep_cnt = s_r.beep_cnt - 1'b1;

		case (s_r.state)
			ST_INIT:
			begin
				// Restore stored settings once after reset
				s_nxt.bore = nv_bore_in;
				s_nxt.rate = nv_rate_in;
				s_nxt.rate_nv = nv_rate_in;
				s_nxt.units = nv_units_in;
				s_nxt.dose = nv_dose_in;
				s_nxt.dir = nv_dir_in;
				s_nxt.al_en = nv_al_in;
				s_nxt.safe = nv_safe_in;
				s_nxt.beep_cnt = BEEP_CYCLES[BEEP_CW-1:0];
				s_nxt.state = ST_STOP;
			end
			ST_STOP, ST_RUN, ST_PAUSE:
			begin
				// Commands
				if (cmd_wr)
				begin
					s_nxt.alarm = 1'b0;
					s_nxt.reply_err = ERR_NONE;
					s_nxt.reply_data = '0;
					case (op)
						OP_STATUS: ;
						OP_BORE_SET:
							if (s_r.state == ST_RUN)
								s_nxt.reply_err = ERR_REFUSED;
							else if (!bore_in_range(val))
								s_nxt.reply_err = ERR_OUT_OF_RANGE;
							else
							begin
								// Other settings are left as they are
								s_nxt.bore = val;
								s_nxt.inf_tot = '0;
								s_nxt.wdr_tot = '0;
								setting = 1'b1;
								saved = 1'b1;
							end
						OP_FLOW_SPEED:
							if (s_r.state == ST_RUN && has_arg && aux != s_r.units)
								s_nxt.reply_err = ERR_REFUSED;
							else if (s_r.state == ST_RUN)
								s_nxt.rate = val;
							else
							begin
								s_nxt.rate = val;
								s_nxt.rate_nv = val;
								if (has_arg)
									s_nxt.units = aux;
								setting = 1'b1;
								saved = 1'b1;
							end
						OP_DOSE_TARGET:
							if (s_r.state == ST_RUN)
								s_nxt.reply_err = ERR_REFUSED;
							else
							begin
								s_nxt.dose = val;
								setting = 1'b1;
								saved = 1'b1;
							end
						OP_HEADING:
							if (!has_arg)
								s_nxt.reply_data = {27'h0000000, s_r.dir};
							else if (s_r.state == ST_RUN && s_r.dose != 16'h0000)
								s_nxt.reply_err = ERR_REFUSED;
							else
							begin
								// Accumulation follows the new heading at once
								s_nxt.dir = aux[0];
								s_nxt.reply_data = {27'h0000000, aux[0]};
								setting = s_r.state != ST_RUN;
								saved = 1'b1;
							end
						OP_START: ;
						OP_HALT: ;
						OP_CLEAR_DELIVERED:
						begin
							s_nxt.inf_tot = '0;
							s_nxt.wdr_tot = '0;
						end
						OP_DELIVERED_QUERY:
							s_nxt.reply_data = {s_r.wdr_tot, s_r.inf_tot};
						OP_ALARM_EN:
						begin
							s_nxt.al_en = aux[0];
							setting = 1'b1;
							saved = 1'b1;
						end
						OP_SAFE_MODE:
						begin
							s_nxt.safe = aux[0];
							setting = 1'b1;
							saved = 1'b1;
						end
						default: s_nxt.reply_err = ERR_BAD_OP;
					endcase
				end
				s_nxt.nv_save = saved;

				// Volume accumulation while the motor turns
				if (vol_tick && s_r.motor_run)
				begin
					if (s_r.dir == DIR_PULL_IN)
						s_nxt.wdr_tot = total_step(s_nxt.wdr_tot);
					else
						s_nxt.inf_tot = total_step(s_nxt.inf_tot);
					s_nxt.moved = s_r.moved + 16'h0001;
					// Phase ends when the dose is reached from phase start
					if (s_r.dose != 16'h0000 && s_r.moved + 16'h0001 >= s_r.dose)
					begin
						s_nxt.state = ST_STOP;
						s_nxt.phase = PHASE_FIRST;
					end
				end

				// Program sequencing; a stall outranks any command
				if (stall_det && s_r.state == ST_RUN)
				begin
					s_nxt.state = ST_PAUSE;
					s_nxt.alarm = 1'b1;
					s_nxt.alarm_msg = s_r.safe;
				end
				else if (stop_req && s_r.state == ST_RUN && s_nxt.state == ST_RUN)
					s_nxt.state = ST_PAUSE;
				else if (stop_req && s_r.state == ST_PAUSE)
					s_nxt.state = ST_STOP;
				else if (setting && s_r.state == ST_PAUSE)
					s_nxt.state = ST_STOP;
				else if (start_req && s_r.state == ST_PAUSE && can_start)
					s_nxt.state = ST_RUN;
				else if (start_req && s_r.state == ST_STOP && can_start)
				begin
					s_nxt.state = ST_RUN;
					s_nxt.phase = PHASE_FIRST;
					s_nxt.moved = '0;
				end
				else if (start_req && !can_start && cmd_wr)
					s_nxt.reply_err = ERR_REFUSED;
			end
			default: s_nxt.state = ST_STOP;
		endcase

		s_nxt.motor_run = s_nxt.state == ST_RUN && s_nxt.rate != 16'h0000;
		s_nxt.buzzer = (s_nxt.beep_cnt != '0) || (s_nxt.alarm && s_nxt.al_en);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.state <= ST_INIT;
			s_r.phase <= PHASE_FIRST;
			s_r.bore <= BORE_RST;
			s_r.rate <= RATE_RST;
			s_r.rate_nv <= RATE_RST;
			s_r.units <= UNITS_RST;
			s_r.dose <= DOSE_RST;
			s_r.dir <= DIR_PUSH_OUT;
		end
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign motor_run = s_r.motor_run;
	assign motor_dir = s_r.dir;
	assign buzzer = s_r.buzzer;
	assign alarm_msg = s_r.alarm_msg;
	assign nv_save = s_r.nv_save;
	// Running rate edits stay out of storage
	assign nv_rate = s_r.rate_nv;
	assign nv_bore = s_r.bore;
	assign nv_units = s_r.units;
	assign nv_dose = s_r.dose;
	assign nv_dir = s_r.dir;
	assign nv_al = s_r.al_en;
	assign nv_safe = s_r.safe;

endmodule

// file: tb/sppc_chk_sva.sv
`timescale 1ns/1ps
module sppc_chk
	import sppc_pkg::*;
#(
	parameter int BEEP_CYCLES = BEEP_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [3:0] wstrb,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic stall_det,
	input wire logic motor_run,
	input wire logic motor_dir,
	input wire logic buzzer,
	input wire logic alarm_msg,
	input wire logic nv_save,
	input wire logic [15:0] nv_rate
);
	// ------------------------------------------------------------
	// Cycles since reset, saturating
	// ------------------------------------------------------------
	logic [31:0] cyc_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cyc_r <= 32'h00000000;
		else if (cyc_r != 32'hffffffff)
			cyc_r <= cyc_r + 32'h00000001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_cmd;
		s_wr ##0 (awaddr == SPPC_CMD_OFF && wstrb == 4'hf);
	endsequence
	sequence s_stall;
		motor_run && stall_det;
	endsequence
	AST_BEEP_ON: assert property (cyc_r == 8'h04 |-> buzzer)
		else $error("power-on beep missing");
	AST_BEEP_OFF: assert property (cyc_r == BEEP_CYCLES + 4 |-> !buzzer)
		else $error("power-on beep too long");
	AST_WR_RESP: assert property (s_wr |=> bvalid)
		else $error("write response late");
	AST_RD_RESP: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_UNMAPPED: assert property (arvalid && arready && araddr > SPPC_DOSE_OFF
		|=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_STALL_STOP: assert property (s_stall |-> ##[1:2] !motor_run)
		else $error("motor runs on after stall");
	AST_MSG_PULSE: assert property (alarm_msg |=> !alarm_msg)
		else $error("alarm message not a pulse");
	AST_CMD_QUIET: assert property (s_cmd ##0 cyc_r > BEEP_CYCLES + 4 |-> ##[1:3] !buzzer)
		else $error("buzzer not silenced by command");
	AST_SAVE_PULSE: assert property (nv_save |=> !nv_save)
		else $error("save strobe not a pulse");
	AST_RATE_KEEP: assert property ($changed(nv_rate) |-> !$past(motor_run))
		else $error("running rate stored");
	// Restore after reset loads the heading without a save
	AST_DIR_SAVED: assert property (cyc_r > 32'h1 && $changed(motor_dir) |-> nv_save)
		else $error("heading change not stored");
endmodule

bind sppc_top sppc_chk #(.BEEP_CYCLES(BEEP_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
	.wstrb(wstrb), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .araddr(araddr),
	.rvalid(rvalid), .rdata(rdata), .rresp(rresp), .stall_det(stall_det),
	.motor_run(motor_run), .motor_dir(motor_dir), .buzzer(buzzer), .alarm_msg(alarm_msg),
	.nv_save(nv_save),
	.nv_rate(nv_rate));

// file: tb/sppc_host.sv
`timescale 1ns/1ps
module sppc_host
(
	input wire logic aclk,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic awvalid,
	output logic [7:0] awaddr,
	output logic wvalid,
	output logic [31:0] wdata,
	output logic bready,
	output logic arvalid,
	output logic [7:0] araddr,
	output logic rready
);
	// ------------------------------------------------------------
	// Bus master; released lines show inverted values
	// ------------------------------------------------------------
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		wdata <= d;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && awready)
			begin
				aw = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (w && wready)
			begin
				w = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		do
			@(posedge aclk);
		while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		{arvalid, rready} <= 2'h3;
		araddr <= a;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do
			@(posedge aclk);
		while (!rvalid);
		rready <= 1'b0;
	endtask
endmodule

// file: tb/sppc_top_tb.sv
`timescale 1ns/1ps
module sppc_top_tb;
	import sppc_pkg::*;
	localparam logic [31:0] EM = 32'h3000_0000;
	localparam logic [31:0] RF = {2'h0, ERR_REFUSED, 28'h0};
	logic aclk;
	logic aresetn;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic trig_in, vol_tick, stall_det;
	logic [15:0] nvb = 16'h0000, nvr = 16'h0000, nvd = 16'h0000, b;
	logic [1:0] nvu = 2'h0;
	logic nvdir = 1'b0, nval = 1'b1, nvs = 1'b1;
	logic nv_save, nv_dir, nv_al, nv_safe;
	logic [15:0] nv_bore, nv_rate, nv_dose;
	logic [1:0] nv_units;
	logic [33:0] q_exp[$];
	logic [31:0] q_msk[$];
	logic [15:0] bad[2] = '{16'h0009, 16'h1389};
	logic [15:0] bt[4] = '{16'h000a, 16'h1388, 16'h0579, 16'h0578};
	logic [3:0] ml = 4'b0110;
	int fails, n_compared, cyc, n;
	sppc_top #(.BEEP_CYCLES(8)) uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .trig_in(trig_in), .vol_tick(vol_tick),
		.stall_det(stall_det), .nv_bore_in(nvb), .nv_rate_in(nvr), .nv_units_in(nvu),
		.nv_dose_in(nvd), .nv_dir_in(nvdir), .nv_al_in(nval), .nv_safe_in(nvs), .motor_run(),
		.motor_dir(), .buzzer(), .alarm_msg(), .nv_save(nv_save), .nv_bore(nv_bore),
		.nv_rate(nv_rate), .nv_units(nv_units), .nv_dose(nv_dose), .nv_dir(nv_dir),
		.nv_al(nv_al), .nv_safe(nv_safe));
	sppc_host host (.aclk(aclk), .awready(awready), .wready(wready), .bvalid(bvalid),
		.arready(arready), .rvalid(rvalid), .awvalid(awvalid), .awaddr(awaddr),
		.wvalid(wvalid), .wdata(wdata), .bready(bready), .arvalid(arvalid), .araddr(araddr),
		.rready(rready));
	// Settings store; survives resets so restore can be checked
	always @(posedge aclk)
	begin
		if (nv_save)
		begin
			{nvb, nvr, nvu, nvd} <= {nv_bore, nv_rate, nv_units, nv_dose};
			{nvdir, nval, nvs} <= {nv_dir, nv_al, nv_safe};
		end
	end
	// ------------------------------------------------------------
	// Stimulus helpers
	// ------------------------------------------------------------
	task automatic cmd(input sppc_op_t op, input logic [15:0] v = 16'h0000,
		input logic [1:0] x = 2'h0, input logic h = 1'b0);
		host.wr(SPPC_CMD_OFF, {op, x, h, 9'h000, v});
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ex,
		input logic [1:0] rs = 2'h0);
		q_exp.push_back({rs, ex});
		q_msk.push_back(mk);
		host.rd(a);
	endtask
	task automatic tick(input int k);
		repeat (k)
		begin
			@(posedge aclk);
			vol_tick <= 1'b1;
			@(posedge aclk);
			vol_tick <= 1'b0;
		end
	endtask
	task automatic trig;
		@(posedge aclk);
		trig_in <= 1'b0;
		repeat (3) @(posedge aclk);
		trig_in <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
	task automatic end_sim;
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		aclk = 1'b0;
		forever
			#2.5 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// Read checker and timeout
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		logic [33:0] e;
		logic [31:0] m;
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			end_sim();
		end
		else if (rvalid && rready)
		begin
			e = q_exp.pop_front();
			m = q_msk.pop_front();
			n_compared++;
			if ({rresp, rdata & m} !== e)
			begin
				fails++;
				$display("MISMATCH %0t got %h want %h", $time, {rresp, rdata & m}, e);
			end
		end
	end
	initial
	begin
		{aresetn, vol_tick, stall_det} = 3'h0;
		trig_in = 1'b1;
		fails = 0;
		n_compared = 0;
		cyc = 0;
		void'($urandom(27));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (20) @(posedge aclk);
		cmd(OP_START);
		chk(SPPC_REPLY_OFF, EM, RF);
		chk(SPPC_STATUS_OFF, 32'h3, 32'h1);
		foreach (bad[i])
		begin
			cmd(OP_BORE_SET, bad[i]);
			chk(SPPC_REPLY_OFF, EM, {2'h0, ERR_OUT_OF_RANGE, 28'h0});
		end
		b = 16'h000a + 16'($urandom % 4991);
		cmd(OP_BORE_SET, b);
		chk(SPPC_BORE_OFF, 32'hffff, {16'h0, b});
		foreach (bt[i])
		begin
			cmd(OP_BORE_SET, bt[i]);
			chk(SPPC_STATUS_OFF, 32'h20, {26'h0, ml[i], 5'h0});
		end
		cmd(OP_FLOW_SPEED, 16'h0064, 2'h0, 1'b1);
		cmd(OP_DOSE_TARGET);
		cmd(OP_HEADING, 16'h0, {1'b0, DIR_PUSH_OUT}, 1'b1);
		cmd(OP_START);
		chk(SPPC_STATUS_OFF, 32'hf01b, 32'h100a);
		n = 1 + $urandom % 50;
		tick(n);
		cmd(OP_HEADING, 16'h0, {1'b0, DIR_PULL_IN}, 1'b1);
		tick(3);
		cmd(OP_HEADING);
		chk(SPPC_REPLY_OFF, 32'h3fffffff, 32'h1);
		chk(SPPC_STATUS_OFF, 32'h18, 32'h18);
		chk(SPPC_WDR_OFF, 32'hffffffff, 32'h3);
		cmd(OP_DELIVERED_QUERY);
		chk(SPPC_REPLY_OFF, 32'h3fffffff, {4'h0, 14'h0003, 14'(n)});
		cmd(OP_FLOW_SPEED, 16'h00c8);
		cmd(OP_FLOW_SPEED, 16'h00c8, 2'h1, 1'b1);
		chk(SPPC_REPLY_OFF, EM, RF);
		chk(SPPC_RATE_OFF, 32'h3ffff, 32'h000c8);
		cmd(OP_BORE_SET, 16'h07d0);
		chk(SPPC_REPLY_OFF, EM, RF);
		chk(SPPC_BORE_OFF, 32'hffff, 32'h0578);
		cmd(OP_HALT);
		chk(SPPC_STATUS_OFF, 32'h7, 32'h7);
		cmd(OP_START);
		@(posedge aclk);
		stall_det <= 1'b1;
		@(posedge aclk);
		stall_det <= 1'b0;
		chk(SPPC_STATUS_OFF, 32'hcb, 32'hc3);
		cmd(OP_STATUS);
		chk(SPPC_STATUS_OFF, 32'hc0, 32'h0);
		cmd(OP_START);
		cmd(OP_CLEAR_DELIVERED);
		chk(SPPC_INF_OFF, 32'hffffffff, 32'h0);
		chk(SPPC_WDR_OFF, 32'hffffffff, 32'h0);
		cmd(OP_HEADING, 16'h0, {1'b0, DIR_PUSH_OUT}, 1'b1);
		tick(10001);
		chk(SPPC_INF_OFF, 32'hffffffff, 32'h1);
		chk(SPPC_STATUS_OFF, 32'h3, 32'h2);
		cmd(OP_HALT);
		cmd(OP_DOSE_TARGET, 16'h0003);
		chk(SPPC_STATUS_OFF, 32'h3, 32'h1);
		cmd(OP_BORE_SET, 16'h05dc);
		chk(SPPC_DOSE_OFF, 32'hffff, 32'h3);
		chk(SPPC_INF_OFF, 32'hffffffff, 32'h0);
		cmd(OP_START);
		tick(2);
		cmd(OP_HEADING, 16'h0, {1'b0, DIR_PULL_IN}, 1'b1);
		chk(SPPC_REPLY_OFF, EM, RF);
		chk(SPPC_STATUS_OFF, 32'h13, 32'h2);
		cmd(OP_HALT);
		cmd(OP_START);
		tick(1);
		chk(SPPC_STATUS_OFF, 32'h3, 32'h1);
		trig();
		chk(SPPC_STATUS_OFF, 32'h3, 32'h2);
		trig();
		chk(SPPC_STATUS_OFF, 32'h3, 32'h3);
		cmd(OP_ALARM_EN);
		cmd(OP_SAFE_MODE, 16'h0, 2'h1);
		chk(SPPC_STATUS_OFF, 32'h303, 32'h201);
		// Power cycle: stored settings return, totals do not
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (20) @(posedge aclk);
		chk(SPPC_RATE_OFF, 32'h3ffff, 32'h00064);
		chk(SPPC_BORE_OFF, 32'hffff, 32'h05dc);
		chk(SPPC_DOSE_OFF, 32'hffff, 32'h3);
		chk(SPPC_STATUS_OFF, 32'h337, 32'h221);
		chk(SPPC_INF_OFF, 32'hffffffff, 32'h0);
		chk(8'h20, 32'hffffffff, 32'h0, 2'h2);
		@(posedge aclk);
		end_sim();
	end
endmodule
